// *** hdl/bpm_regs.sv ***
// Summary of operation
// - six-bit high battery target, 1.5 V per code, resets to -75 V.
// - six-bit low battery target, 1.5 V per code, resets to -24 V.
// - three-bit selector picks transistors one to six; 110 and 111 undefined.
// - read-only byte reports live power of the selected transistor.
// - transistors one, two, five, six read 30.4 mW per code.
// - transistors three and four read 3.62 mW per code.
`timescale 1ns/1ps
`default_nettype none
module bpm_regs #(
  parameter int NUM_TR = bpm_pkg::NUM_TRANSISTORS,
  parameter int PW = bpm_pkg::POWER_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bpm_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [bpm_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [bpm_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_TR*PW-1:0] transistor_power_in,
  output logic [bpm_pkg::LEVEL_W-1:0] high_battery_level,
  output logic [bpm_pkg::LEVEL_W-1:0] low_battery_level
);

  typedef struct packed {
    logic [bpm_pkg::LEVEL_W-1:0] high_bat;
    logic [bpm_pkg::LEVEL_W-1:0] low_bat;
    logic [bpm_pkg::SEL_W-1:0] pwr_sel;
    logic pready;
    logic pslverr;
    logic [bpm_pkg::APB_DATA_W-1:0] prdata;
  } bpm_regs_s;

  bpm_regs_s st_q;
  bpm_regs_s st_d;
  bpm_pkg::bpm_reg_e reg_sel;
  logic setup_phase;
  logic write_done;

  bpm_sel_if sel_bus ();

  // map a byte address to a register; misaligned words are unmapped
  function automatic bpm_pkg::bpm_reg_e decode_reg(
    input logic [bpm_pkg::APB_ADDR_W-1:0] addr
  );
    logic [bpm_pkg::IDX_W-1:0] idx;
    idx = addr[bpm_pkg::APB_ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      return bpm_pkg::REG_NONE;
    end
    case (idx)
      bpm_pkg::IDX_HIGH_BAT: return bpm_pkg::REG_HIGH;
      bpm_pkg::IDX_LOW_BAT: return bpm_pkg::REG_LOW;
      bpm_pkg::IDX_PWR_SEL: return bpm_pkg::REG_SEL;
      bpm_pkg::IDX_PWR_READ: return bpm_pkg::REG_READ;
      bpm_pkg::IDX_PWR_STAT: return bpm_pkg::REG_STAT;
      default: return bpm_pkg::REG_NONE;
    endcase
  endfunction : decode_reg

  // place a narrow field in the low bits, upper bits read zero
  function automatic logic [bpm_pkg::APB_DATA_W-1:0] zext8(
    input logic [7:0] val
  );
    return {24'h000000, val};
  endfunction : zext8

  // the power mux sits in its own module and sees only the selector
  bpm_pwr_sel #(
    .NUM_TR(NUM_TR),
    .PW(PW)
  ) u_pwr_sel (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .transistor_power_in(transistor_power_in),
    .sel_port(sel_bus.mon)
  );

  assign sel_bus.sel = st_q.pwr_sel;

  // apb phase decode
  assign reg_sel = decode_reg(paddr);
  assign setup_phase = psel && !penable;
  assign write_done = psel && penable && pready && pwrite;

  // register next state and bus answer
  always_comb begin
    st_d = st_q;
    // no wait state: ready rises in the first access cycle, then drops,
    // so a master holding the access phase sees exactly one ready edge
    st_d.pready = setup_phase;
    if (!setup_phase) begin
      st_d.pslverr = 1'b0;
      st_d.prdata = '0;
    end else begin
      st_d.pslverr = (reg_sel == bpm_pkg::REG_NONE);
      // read data is captured in setup so it is stable while ready is high
      case (reg_sel)
        bpm_pkg::REG_HIGH: begin
          st_d.prdata = zext8({2'b00, st_q.high_bat});
        end
        bpm_pkg::REG_LOW: begin
          st_d.prdata = zext8({2'b00, st_q.low_bat});
        end
        bpm_pkg::REG_SEL: begin
          st_d.prdata = zext8({5'b00000, st_q.pwr_sel});
        end
        bpm_pkg::REG_READ: begin
          st_d.prdata = zext8(sel_bus.readout);
        end
        bpm_pkg::REG_STAT: begin
          st_d.prdata = '0;
          st_d.prdata[bpm_pkg::STAT_FINE_BIT] = sel_bus.fine_scale;
          st_d.prdata[bpm_pkg::STAT_UNDEF_BIT] = sel_bus.undefined_code;
        end
        default: begin
          st_d.prdata = '0;
        end
      endcase
    end
    // writes land on the ready edge; only byte lane 0 carries data,
    // so a write with pstrb[0] low leaves the register untouched
    if (write_done && pstrb[0]) begin
      case (reg_sel)
        bpm_pkg::REG_HIGH: begin
          st_d.high_bat = pwdata[bpm_pkg::LEVEL_W-1:0];
        end
        bpm_pkg::REG_LOW: begin
          st_d.low_bat = pwdata[bpm_pkg::LEVEL_W-1:0];
        end
        bpm_pkg::REG_SEL: begin
          // undefined codes are stored as written; the mux reads zero
          st_d.pwr_sel = pwdata[bpm_pkg::SEL_W-1:0];
        end
        default: begin
          // readout and status are read-only, writes are dropped
          st_d.pwr_sel = st_q.pwr_sel;
        end
      endcase
    end
  end

  // single register stage for all state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{high_bat: bpm_pkg::HIGH_BAT_RST,
                low_bat: bpm_pkg::LOW_BAT_RST,
                pwr_sel: bpm_pkg::PWR_SEL_RST,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops; no ordering check between the targets,
  // software is trusted to keep high at or above low
  assign high_battery_level = st_q.high_bat;
  assign low_battery_level = st_q.low_bat;
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;

endmodule : bpm_regs
`default_nettype wire

// *** inc/bpm_pkg.sv ***
`default_nettype none
package bpm_pkg;

  // apb geometry; each register takes one aligned 32-bit word
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam int IDX_W = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_HIGH_BAT = 10'h04A;
  localparam logic [IDX_W-1:0] IDX_LOW_BAT = 10'h04B;
  localparam logic [IDX_W-1:0] IDX_PWR_SEL = 10'h04C;
  localparam logic [IDX_W-1:0] IDX_PWR_READ = 10'h04D;
  localparam logic [IDX_W-1:0] IDX_PWR_STAT = 10'h070;

  // field layout
  localparam int LEVEL_W = 6;
  localparam int SEL_W = 3;
  localparam int POWER_W = 8;
  localparam int NUM_TRANSISTORS = 6;
  localparam int STAT_FINE_BIT = 0;
  localparam int STAT_UNDEF_BIT = 1;

  // reset values
  localparam logic [LEVEL_W-1:0] HIGH_BAT_RST = 6'h32;
  localparam logic [LEVEL_W-1:0] LOW_BAT_RST = 6'h10;
  localparam logic [SEL_W-1:0] PWR_SEL_RST = 3'h0;
  localparam logic [POWER_W-1:0] PWR_READ_RST = 8'h00;

  // transistor selector codes
  typedef enum logic [SEL_W-1:0] {
    SEL_Q1 = 3'b000,
    SEL_Q2 = 3'b001,
    SEL_Q3 = 3'b010,
    SEL_Q4 = 3'b011,
    SEL_Q5 = 3'b100,
    SEL_Q6 = 3'b101
  } bpm_sel_e;

  // decoded register targets
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_HIGH = 3'b001,
    REG_LOW = 3'b010,
    REG_SEL = 3'b011,
    REG_READ = 3'b100,
    REG_STAT = 3'b101
  } bpm_reg_e;

endpackage : bpm_pkg
`default_nettype wire

// *** inc/bpm_sel_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries the selector to the power mux and the chosen reading back
interface bpm_sel_if;
  logic [bpm_pkg::SEL_W-1:0] sel;
  logic [bpm_pkg::POWER_W-1:0] readout;
  logic fine_scale;
  logic undefined_code;

  modport ctl (output sel, input readout, input fine_scale,
               input undefined_code);
  modport mon (input sel, output readout, output fine_scale,
               output undefined_code);
endinterface : bpm_sel_if
`default_nettype wire

// *** hdl/bpm_pwr_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpm_pwr_sel #(
  parameter int NUM_TR = bpm_pkg::NUM_TRANSISTORS,
  parameter int PW = bpm_pkg::POWER_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [NUM_TR*PW-1:0] transistor_power_in,
  bpm_sel_if.mon sel_port
);

  typedef struct packed {
    logic [PW-1:0] readout;
    logic fine_scale;
    logic undefined_code;
  } bpm_mux_s;

  bpm_mux_s st_q;
  bpm_mux_s st_d;

  // track the selected transistor every cycle so the reading stays live
  always_comb begin
    st_d = st_q;
    st_d.undefined_code = 1'b0;
    st_d.fine_scale = 1'b0;
    case (sel_port.sel)
      bpm_pkg::SEL_Q1, bpm_pkg::SEL_Q2,
      bpm_pkg::SEL_Q5, bpm_pkg::SEL_Q6: begin
        // power stage: 30.4 mW per code
        st_d.readout = transistor_power_in[int'(sel_port.sel)*PW +: PW];
      end
      bpm_pkg::SEL_Q3, bpm_pkg::SEL_Q4: begin
        // small transistors: 3.62 mW per code
        st_d.readout = transistor_power_in[int'(sel_port.sel)*PW +: PW];
        st_d.fine_scale = 1'b1;
      end
      default: begin
        // undefined codes read zero rather than stale data
        st_d.readout = '0;
        st_d.undefined_code = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{readout: bpm_pkg::PWR_READ_RST, fine_scale: 1'b0,
                undefined_code: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign sel_port.readout = st_q.readout;
  assign sel_port.fine_scale = st_q.fine_scale;
  assign sel_port.undefined_code = st_q.undefined_code;

endmodule : bpm_pwr_sel
`default_nettype wire

// *** dv/bpm_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpm_regs_properties #(
  parameter int NUM_TR = 6,
  parameter int PW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [NUM_TR*PW-1:0] transistor_power_in,
  input wire logic [5:0] high_battery_level,
  input wire logic [5:0] low_battery_level
);
  logic [2:0] sel_q;
  logic [7:0] pick;
  // shadow selector, so the readout can be predicted from the pins
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) sel_q <= 3'h0;
    else if (psel && penable && pwrite && pready && pstrb[0]
             && paddr == 12'h130) sel_q <= pwdata[2:0];
  // undefined codes read zero, so no stale byte can leak out
  assign pick = (sel_q > 3'h5) ? 8'h00
                : transistor_power_in[{sel_q, 3'h0} +: 8];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence rd_s(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence wr_s(logic [11:0] a);
    psel && penable && pwrite && pready && pstrb[0] && paddr == a;
  endsequence
  chk_answer_once: assert property (
      psel && !penable |=> pready ##1 !pready)
    else $error("answer not a single cycle");
  chk_high_reset: assert property (
      $rose(rst_b) |-> high_battery_level == 6'h32)
    else $error("high target reset value wrong");
  chk_high_write: assert property (
      wr_s(12'h128) |=> high_battery_level == $past(pwdata[5:0]))
    else $error("high target write lost");
  chk_high_hold: assert property (
      !(psel && penable && paddr == 12'h128)
      |=> $stable(high_battery_level))
    else $error("high target changed unasked");
  chk_low_reset: assert property (
      $rose(rst_b) |-> low_battery_level == 6'h10)
    else $error("low target reset value wrong");
  chk_low_write: assert property (
      wr_s(12'h12C) |=> low_battery_level == $past(pwdata[5:0]))
    else $error("low target write lost");
  chk_low_hold: assert property (
      !(psel && penable && paddr == 12'h12C)
      |=> $stable(low_battery_level))
    else $error("low target changed unasked");
  chk_sel_read: assert property (
      rd_s(12'h130) |=> prdata == {29'h0, $past(sel_q)})
    else $error("selector readback wrong");
  chk_power_read: assert property (
      $stable(pick) [*3] ##0 rd_s(12'h134)
      |=> prdata == {24'h0, $past(pick)})
    else $error("power readout wrong");
endmodule : bpm_regs_properties
bind bpm_regs bpm_regs_properties #(.NUM_TR(NUM_TR), .PW(PW)) chk_i (
  .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .transistor_power_in, .high_battery_level,
  .low_battery_level);
`default_nettype wire

// *** dv/bpm_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpm_regs_tb;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [47:0] tpi;
  logic [5:0] hi_lvl, lo_lvl;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  bpm_regs bpm_regs_i (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .transistor_power_in(tpi),
    .high_battery_level(hi_lvl), .low_battery_level(lo_lvl));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task complete_run;
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // watchdog: a slave that never answers must not hang the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // keep holds psel so the next setup follows at once
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
            input logic keep);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!keep) psel <= 1'b0;
    if (!keep) @(posedge ref_clk);
  endtask : xfer
  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, 1'b0);
    chk(rd, e);
    // a mapped register never answers with an error
    chk({31'h0, err}, 32'h0);
  endtask : rdc
  // main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    tpi = 48'h665544332211;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk({26'h0, hi_lvl}, 32'h32);
    chk({26'h0, lo_lvl}, 32'h10);
    rdc(12'h128, 32'h32);
    rdc(12'h12C, 32'h10);
    rdc(12'h130, 32'h0);
    // high kept at or above low, as a supply would demand
    xfer(12'h128, 1'b1, 32'hFFFFFFFF, 1'b1);
    xfer(12'h12C, 1'b1, 32'hFFFFFFC0, 1'b0);
    chk({26'h0, hi_lvl}, 32'h3F);
    chk({26'h0, lo_lvl}, 32'h0);
    // a write with byte lane 0 off must not land
    pstrb <= 4'h0;
    xfer(12'h128, 1'b1, 32'h5, 1'b0);
    pstrb <= 4'hF;
    rdc(12'h128, 32'h3F);
    rdc(12'h12C, 32'h0);
    // every selector code, with the power inputs moving each time
    for (int s = 0; s < 8; s++) begin
      tpi <= tpi + 48'h0D0C0B0A0908;
      xfer(12'h130, 1'b1, 32'(s) | 32'hF8, 1'b0);
      rdc(12'h130, 32'(s));
      rdc(12'h134, (s < 6) ? 32'(tpi[8*s +: 8]) : 32'h0);
      rdc(12'h1C0, {30'h0, s > 5, s == 2 || s == 3});
    end
    xfer(12'h130, 1'b1, 32'h2, 1'b0);
    xfer(12'h134, 1'b1, 32'hAA, 1'b0);
    rdc(12'h134, 32'(tpi[23:16]));
    // mid-run reset must bring back targets and selector
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk({26'h0, hi_lvl}, 32'h32);
    chk({26'h0, lo_lvl}, 32'h10);
    rdc(12'h130, 32'h0);
    rdc(12'h134, 32'(tpi[7:0]));
    xfer(12'h200, 1'b0, 32'h0, 1'b0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // a misaligned write is refused and leaves the target alone
    xfer(12'h12A, 1'b1, 32'h1, 1'b0);
    chk({31'h0, err}, 32'h1);
    rdc(12'h128, 32'h32);
    complete_run();
  end
endmodule : bpm_regs_tb
`default_nettype wire
